// [logic/sram_byte_cfg.svh]
// Constants of the byte-writable synchronous SRAM block: geometry, register
// offsets, field positions and reset values.
// Assumes it is included by bare name from the package and from the bench.
`ifndef SRAM_BYTE_CFG_SVH
`define SRAM_BYTE_CFG_SVH

// Array geometry
`define SRAM_WORDS        16384
`define SRAM_ADDR_W       14
`define SRAM_DATA_W       16
`define SRAM_BYTE_W       8

// Register bus geometry
`define REG_ADDR_W        8
`define REG_DATA_W        32

// Register byte offsets
`define REG_CTRL_OFS      8'h00
`define REG_STATUS_OFS    8'h04
`define REG_WCOUNT_OFS    8'h08
`define REG_ACOUNT_OFS    8'h0C
`define REG_RCOUNT_OFS    8'h10

// Control fields
`define CTRL_INHIBIT_BIT  0
`define CTRL_MUTE_BIT     1
`define CTRL_W            2
`define CTRL_RESET        2'h0

// Status fields
`define STAT_ADDR_LSB     0
`define STAT_KIND_LSB     16
`define STAT_HOLD_BIT     20

// Bus responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [logic/sram_byte_pkg.sv]
// Types shared by the byte-writable synchronous SRAM block.
// Assumes sram_byte_cfg.svh is on the include path.
package sram_byte_pkg;
`include "sram_byte_cfg.svh"

   // Kind of cycle captured at a clock edge
   typedef enum logic [1:0] {
      cyc_idle,
      cyc_read,
      cyc_write
   } cycle_kind_type;

endpackage

// [logic/sram_byte_array.sv]
// Word array with per-byte write enables and a registered read port.
// Assumes one clock and a synchronous active-low reset of the read register.
`timescale 1ns/1ps
module sram_byte_array
   import sram_byte_pkg::*;
#(
   parameter int WORDS  = `SRAM_WORDS,
   parameter int ADDR_W = `SRAM_ADDR_W,
   parameter int DATA_W = `SRAM_DATA_W
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [DATA_W/8-1:0] byte_we,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic                rd_en,
   output logic      [DATA_W-1:0]   rdata_q
);

   localparam int LANES = DATA_W / `SRAM_BYTE_W;

   // Refuse shapes the lane split cannot serve
   if (DATA_W % `SRAM_BYTE_W != 0 || WORDS > (1 << ADDR_W)) begin : g_bad
      $error("sram_byte_array: width or depth not supported");
   end

   wire [DATA_W-1:0] word_at_addr;   // Addressed word, assembled from the lanes

   ////////////////////////////////////////////////////////////////////////////
   // One storage lane per byte, each gated by its own enable; separate lane
   // arrays keep every array written by a single process
   for (genvar b = 0; b < LANES; b++) begin : g_lane
      logic [7:0] lane_mem [WORDS];   // Storage, no reset on purpose
      always_ff @(posedge aclk) begin
         if (byte_we[b]) begin
            lane_mem[addr] <= wdata[b*8 +: 8];
         end
      end
      assign word_at_addr[b*8 +: 8] = lane_mem[addr];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered read; holds its word between reads
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_q <= '0;
      end else if (rd_en) begin
         rdata_q <= word_at_addr;
      end
   end

endmodule

// [logic/sync_sram_byte_write_latch.sv]
// Byte-writable synchronous static RAM interface with late write abort,
// input data latch, registered bank enables and an AXI4-Lite register file.
// Assumes the memory controller runs on aclk, so the pins need no
// synchroniser, and that software reaches the registers over AXI4-Lite.
//
// Contract
// [RQ1] Register synchronous inputs on each rising edge
// [RQ2] Address, bank enables, write select are registered
// [RQ3] Strobes, enable, data, latch act unsampled
// [RQ4] Captured address and control held whole cycle
// [RQ5] Low strobe bits 7:0, high 15:8
// [RQ6] Strobe inactive late cancels that byte write
// [RQ7] Selected only when both bank enables asserted
// [RQ8] Latch control high passes pins through
// [RQ9] Latch control low holds value at fall
// [RQ10] Array of 16384 words, 16 bits each
// [RQ11] Drive pins only while output enable asserted
// [RQ12] Read and write data share the pins
// [RQ13] Transparent write keeps latch control high
// [RQ14] Latched write drops latch control during cycle
// [RQ15] Controller keeps inputs stable around edges
// [RQ16] Write select inactive when selected means read
// [RQ17] Deselected cycle neither reads nor writes
`timescale 1ns/1ps
module sync_sram_byte_write_latch
   import sram_byte_pkg::*;
#(
   parameter int WORDS  = `SRAM_WORDS,
   parameter int ADDR_W = `SRAM_ADDR_W,
   parameter int DATA_W = `SRAM_DATA_W
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Memory pins from the controller
   input  wire logic [ADDR_W-1:0]     address,
   input  wire logic                  registered_write_select_n,
   input  wire logic                  bank_pick_high,
   input  wire logic                  bank_pick_low_n,
   input  wire logic                  low_byte_write_strobe_n,
   input  wire logic                  high_byte_write_strobe_n,
   input  wire logic                  output_enable_n,
   input  wire logic                  input_hold_control,
   input  wire logic [DATA_W-1:0]     shared_data_pins_in,
   output logic      [DATA_W-1:0]     shared_data_pins_out,
   output logic                       shared_data_pins_oe,
   // AXI4-Lite register port
   input  wire logic [`REG_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [`REG_DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [`REG_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [`REG_DATA_W-1:0]     s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready
);

   // Refuse shapes the pins and status fields cannot carry
   if (DATA_W != 2 * `SRAM_BYTE_W || ADDR_W > `STAT_KIND_LSB
       || WORDS > (1 << ADDR_W)) begin : g_bad
      $error("sync_sram_byte_write_latch: unsupported geometry");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [ADDR_W-1:0]      cap_addr_q;     // Address held for the cycle
   cycle_kind_type         cap_kind_q;     // Kind of the captured cycle
   logic [DATA_W-1:0]      latch_q;        // Input data latch content
   logic                   oe_q;           // Pin drive enable
   logic [`CTRL_W-1:0]     ctrl_q;         // Inhibit and mute controls
   logic [31:0]            wcount_q;       // Committed write cycles
   logic [31:0]            acount_q;       // Fully aborted write cycles
   logic [31:0]            rcount_q;       // Read cycles performed

   logic                   awready_q;      // Address slot free
   logic                   wready_q;       // Data slot free
   logic [`REG_ADDR_W-1:0] awaddr_q;       // Held write address
   logic [`REG_DATA_W-1:0] wdata_q;        // Held write data
   logic [3:0]             wstrb_q;        // Held byte strobes
   logic                   bvalid_q;       // Write answer pending
   logic [1:0]             bresp_q;        // Write answer code
   logic                   arready_q;      // Read slot free
   logic                   rvalid_q;       // Read answer pending
   logic [`REG_DATA_W-1:0] rdata_q;        // Read answer data
   logic [1:0]             rresp_q;        // Read answer code

   logic [DATA_W-1:0]      mem_rdata;      // Registered array output

   ////////////////////////////////////////////////////////////////////////////
   // Memory side decode

   // Both bank enables must be asserted at the edge
   wire selected = bank_pick_high & ~bank_pick_low_n; // [RQ7]

   // Kind of cycle this edge opens
   wire cycle_kind_type next_kind =
      !selected                  ? cyc_idle :   // [RQ17]
      registered_write_select_n  ? cyc_read :   // [RQ16]
                                   cyc_write;

   wire inhibit = ctrl_q[`CTRL_INHIBIT_BIT];
   wire mute    = ctrl_q[`CTRL_MUTE_BIT];

   // Late write commits at the closing edge; strobes are looked at
   // directly there, so an inactive strobe cancels its byte
   wire commit     = (cap_kind_q == cyc_write) && !inhibit;
   wire lo_we      = commit && !low_byte_write_strobe_n;  // [RQ5] [RQ6] [RQ3]
   wire hi_we      = commit && !high_byte_write_strobe_n; // [RQ5] [RQ6] [RQ3]
   wire [1:0] b_we = {hi_we, lo_we};
   wire aborted    = commit && !lo_we && !hi_we;          // [RQ6]
   wire do_read    = (cap_kind_q == cyc_read);

   // Transparent latch passes the pins, closed latch gives held data
   wire [DATA_W-1:0] write_data =
      input_hold_control ? shared_data_pins_in : latch_q;  // [RQ8] [RQ9] [RQ12]

   ////////////////////////////////////////////////////////////////////////////
   // Capture of the synchronous inputs; only these copies steer the cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_addr_q <= '0;
         cap_kind_q <= cyc_idle;
      end else begin
         cap_addr_q <= address;    // [RQ1] [RQ2] [RQ4]
         cap_kind_q <= next_kind;  // [RQ1] [RQ2] [RQ4]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input data latch; follows the pins while open, freezes when closed.
   // The frozen value is the last one seen while the control was high.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_q <= '0;
      end else if (input_hold_control) begin
         latch_q <= shared_data_pins_in;  // [RQ8] [RQ9]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Word array, addressed by the captured address
   sram_byte_array #(
      .WORDS  (WORDS),
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W)
   ) u_array (
      .aclk    (aclk),
      .aresetn (aresetn),
      .addr    (cap_addr_q),  // [RQ10]
      .byte_we (b_we),
      .wdata   (write_data),
      .rd_en   (do_read),
      .rdata_q (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive: only during read data, only with output enable asserted.
   // Writes and deselected cycles leave the pins released.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= do_read && !output_enable_n && !mute;  // [RQ11] [RQ12] [RQ17]
      end
   end

   assign shared_data_pins_out = mem_rdata;
   assign shared_data_pins_oe  = oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Activity counters; they wrap silently
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wcount_q <= '0;
         acount_q <= '0;
         rcount_q <= '0;
      end else begin
         if (lo_we || hi_we) begin
            wcount_q <= wcount_q + 32'h1;
         end
         if (aborted) begin
            acount_q <= acount_q + 32'h1;
         end
         if (do_read) begin
            rcount_q <= rcount_q + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register bus decode

   wire aw_take  = s_axi_awvalid && awready_q;
   wire w_take   = s_axi_wvalid && wready_q;
   wire ar_take  = s_axi_arvalid && arready_q;
   // Both halves held and no answer yet outstanding
   wire wr_fire  = !awready_q && !wready_q && !bvalid_q;

   wire wr_ctrl  = (awaddr_q == `REG_CTRL_OFS);
   wire wr_known = wr_ctrl
                   || (awaddr_q == `REG_STATUS_OFS)
                   || (awaddr_q == `REG_WCOUNT_OFS)
                   || (awaddr_q == `REG_ACOUNT_OFS)
                   || (awaddr_q == `REG_RCOUNT_OFS);

   // Status word: captured address, cycle kind, latch control level
   wire [31:0] status_word =
      (32'(cap_addr_q) << `STAT_ADDR_LSB)
      | (32'(cap_kind_q) << `STAT_KIND_LSB)
      | (32'(input_hold_control) << `STAT_HOLD_BIT);

   wire rd_known = (s_axi_araddr == `REG_CTRL_OFS)
                   || (s_axi_araddr == `REG_STATUS_OFS)
                   || (s_axi_araddr == `REG_WCOUNT_OFS)
                   || (s_axi_araddr == `REG_ACOUNT_OFS)
                   || (s_axi_araddr == `REG_RCOUNT_OFS);

   wire [31:0] rd_word =
      (s_axi_araddr == `REG_CTRL_OFS)   ? 32'(ctrl_q) :
      (s_axi_araddr == `REG_STATUS_OFS) ? status_word :
      (s_axi_araddr == `REG_WCOUNT_OFS) ? wcount_q :
      (s_axi_araddr == `REG_ACOUNT_OFS) ? acount_q :
      (s_axi_araddr == `REG_RCOUNT_OFS) ? rcount_q :
                                          32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Write channels: address and data taken in either order, each slot
   // closes on its handshake and reopens when the answer is accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
      end else begin
         if (aw_take) begin
            awready_q <= 1'b0;
            awaddr_q  <= s_axi_awaddr;
         end
         if (w_take) begin
            wready_q <= 1'b0;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            // Unmapped offsets answer with a slave error
            bresp_q  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register; only byte lane 0 carries fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `CTRL_RESET;
      end else if (wr_fire && wr_ctrl && wstrb_q[0]) begin
         ctrl_q <= wdata_q[`CTRL_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: one outstanding read, answered the edge after taking it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= `RESP_OKAY;
      end else if (ar_take) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rd_word;
         rresp_q   <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

endmodule

// [bench/sram_ctrl_model.sv]
// Memory controller model that drives the SRAM pins, two edges per access.
// Assumes the bench calls op just after a rising edge and resolves the wire.
`timescale 1ns/1ps
module sram_ctrl_model (
   input  wire logic   aclk,
   output logic [13:0] address,
   output logic        registered_write_select_n,
   output logic        bank_pick_high,
   output logic        bank_pick_low_n,
   output logic        low_byte_write_strobe_n,
   output logic        high_byte_write_strobe_n,
   output logic        output_enable_n,
   output logic        input_hold_control,
   output logic [15:0] drive_data,
   output logic        drive_en
);
   // Idle: deselected, strobes off, latch open, bus released
   initial begin
      address = 14'h0000;
      drive_data = 16'h0000;
      {registered_write_select_n, bank_pick_high, bank_pick_low_n, low_byte_write_strobe_n,
       high_byte_write_strobe_n, output_enable_n, input_hold_control, drive_en} = 8'hBE;
   end
   ////////////////////////////////////////////////////////////////
   // One access: edge N captures the request, edge N+1 commits or reads
   task automatic op(input logic [13:0] a, input logic [1:0] bank, input logic wr,
                     input logic [1:0] str_n, input logic [15:0] d, input logic latched,
                     input logic oe_n);
      address <= a;
      {bank_pick_high, bank_pick_low_n} <= bank;
      registered_write_select_n <= !wr;
      {high_byte_write_strobe_n, low_byte_write_strobe_n} <= 2'h3;
      output_enable_n <= wr | oe_n;
      input_hold_control <= 1'h1;
      drive_en <= wr;
      drive_data <= d;
      @(posedge aclk);
      // Scramble captured inputs so the device must hold its own copy
      address <= ~a;
      {bank_pick_high, bank_pick_low_n} <= 2'h1;
      registered_write_select_n <= 1'h1;
      // Both strobes high here aborts the write
      {high_byte_write_strobe_n, low_byte_write_strobe_n} <= wr ? str_n : 2'h3;
      if (latched) begin
         input_hold_control <= 1'h0;
         drive_en <= 1'h0;
      end
      @(posedge aclk);
   endtask
endmodule

// [bench/sync_sram_byte_write_latch_checker.sv]
// Checker on the SRAM pins and the register port handshakes.
// Assumes it is bound to the top module and the mute bit stays clear.
`timescale 1ns/1ps
module sync_sram_byte_write_latch_checker #(
   parameter int DATA_W = 16
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic              registered_write_select_n,
   input wire logic              bank_pick_high,
   input wire logic              bank_pick_low_n,
   input wire logic              output_enable_n,
   input wire logic [DATA_W-1:0] shared_data_pins_out,
   input wire logic              shared_data_pins_oe,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic              s_axi_rvalid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Bank decode as seen on the pins
   wire bank_sel = bank_pick_high && !bank_pick_low_n;
   wire rd_sel   = bank_sel && registered_write_select_n;
   sequence s_rd_req;
      rd_sel;
   endsequence
   sequence s_wr_req;
      bank_sel && !registered_write_select_n;
   endsequence
   ////////////////////////////////////////////////////////////////
   property p_oe_cause;
      shared_data_pins_oe |-> !$past(output_enable_n) && $past(rd_sel, 2);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("pins driven without a selected read and enable");
   property p_read_drive;
      s_rd_req ##1 !output_enable_n |=> shared_data_pins_oe;
   endproperty
   a_read_drive: assert property (p_read_drive)
      else $error("selected read did not drive the pins");
   property p_desel_hiz;
      !bank_sel |=> ##1 !shared_data_pins_oe;
   endproperty
   a_desel_hiz: assert property (p_desel_hiz)
      else $error("deselected cycle drove the pins");
   property p_write_hiz;
      s_wr_req |=> ##1 !shared_data_pins_oe;
   endproperty
   a_write_hiz: assert property (p_write_hiz)
      else $error("write cycle drove the pins");
   property p_out_stable;
      !rd_sel |=> ##1 $stable(shared_data_pins_out);
   endproperty
   a_out_stable: assert property (p_out_stable)
      else $error("read data changed without a read");
   property p_aw_to_b;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
   endproperty
   a_aw_to_b: assert property (p_aw_to_b)
      else $error("write response not two edges after address and data");
   property p_ar_to_r;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_ar_to_r: assert property (p_ar_to_r)
      else $error("read response not one edge after address");
   property p_b_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
   endproperty
   a_b_done: assert property (p_b_done)
      else $error("write response not retired after handshake");
endmodule

// [bench/sync_sram_byte_write_latch_tb.sv]
// Bench: memory pins through the controller model, registers over AXI4-Lite.
// Assumes the package, design, checker and controller model compile first.
`timescale 1ns/1ps
`include "sram_byte_cfg.svh"
module sync_sram_byte_write_latch_tb;
   import sram_byte_pkg::*;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [13:0] address;
   logic        registered_write_select_n, bank_pick_high, bank_pick_low_n;
   logic        low_byte_write_strobe_n, high_byte_write_strobe_n, output_enable_n;
   logic        input_hold_control, drive_en, shared_data_pins_oe;
   logic [15:0] drive_data, shared_data_pins_out;
   // Wire level: device, else controller, else the inverse of the last value
   wire  [15:0] shared_data_pins_in = shared_data_pins_oe ? shared_data_pins_out :
                                      drive_en ? drive_data : ~drive_data;
   int          errors = 0, samples_checked = 0, wc = 0, ac = 0, rc = 0;
   logic        inhibit = 1'h0;
   logic [15:0] last_out = 16'h0000;
   logic [15:0] mem_exp [16384];      // Expected array contents
   logic [13:0] addrs [$];            // Addresses written so far
   logic [13:0] a;
   always #5 aclk = ~aclk;
   sram_ctrl_model ctl (.aclk, .address, .registered_write_select_n, .bank_pick_high,
      .bank_pick_low_n, .low_byte_write_strobe_n, .high_byte_write_strobe_n,
      .output_enable_n, .input_hold_control, .drive_data, .drive_en);
   sync_sram_byte_write_latch DUT (.aclk, .aresetn, .address, .registered_write_select_n,
      .bank_pick_high, .bank_pick_low_n, .low_byte_write_strobe_n, .high_byte_write_strobe_n,
      .output_enable_n, .input_hold_control, .shared_data_pins_in, .shared_data_pins_out,
      .shared_data_pins_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Register write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
      bit pa, pw;
      @(posedge aclk);
      pa = 1;
      pw = 1;
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (pa || pw) begin
         @(posedge aclk);
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk({30'h0, s_axi_bresp}, {30'h0, `RESP_OKAY});
   endtask
   // Register read, compared with the expected word and response
   task automatic axi_rd(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= ad;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      chk(s_axi_rdata, ed);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // One memory access through the controller, with the reference model beside it
   task automatic t_op(input logic [13:0] ad, input logic [1:0] bank, input logic wr,
                       input logic [1:0] sn, input logic [15:0] d, input logic lat,
                       input logic oe_n);
      logic sel;
      logic wok;
      sel = (bank == 2'h2);
      wok = sel && wr && !inhibit;
      ctl.op(ad, bank, wr, sn, d, lat, oe_n);
      if (wok && sn == 2'h3) ac++;
      if (wok && sn != 2'h3) wc++;
      if (sel && !wr) rc++;
      if (wok && !sn[0]) mem_exp[ad][7:0] = d[7:0];
      if (wok && !sn[1]) mem_exp[ad][15:8] = d[15:8];
      if (sel && !wr) last_out = mem_exp[ad];
      #1;
      chk({16'h0, shared_data_pins_out}, {16'h0, last_out});
      chk({31'h0, shared_data_pins_oe}, {31'h0, sel && !wr && !oe_n});
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'hC05C));
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(`REG_CTRL_OFS, 32'h0, `RESP_OKAY);
      axi_rd(8'h14, 32'h0, `RESP_SLVERR);
      axi_wr(`REG_WCOUNT_OFS, 32'h5);
      // Full write then random byte lanes, latched or transparent, back to back
      for (int i = 0; i < 10; i++) begin
         a = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : 14'($urandom);
         addrs.push_back(a);
         t_op(a, 2'h2, 1'h1, 2'h0, 16'($urandom), 1'($urandom), 1'h1);
         t_op(a, 2'h2, 1'h1, (i == 2) ? 2'h3 : 2'($urandom), 16'($urandom), i[0], 1'h1);
      end
      foreach (addrs[i]) t_op(addrs[i], 2'h2, 1'h0, 2'h3, 16'h0, 1'h0, 1'h0);
      // Every unselected bank pair: no write, no drive
      for (int b = 0; b < 4; b++) begin
         if (b != 2) begin
            t_op(addrs[2], 2'(b), 1'h1, 2'h0, 16'hA5A5, 1'h0, 1'h1);
            t_op(addrs[2], 2'(b), 1'h0, 2'h3, 16'h0, 1'h0, 1'h0);
         end
      end
      t_op(addrs[2], 2'h2, 1'h0, 2'h3, 16'h0, 1'h0, 1'h1);
      t_op(addrs[2], 2'h2, 1'h0, 2'h3, 16'h0, 1'h0, 1'h0);
      // Write inhibit drops a full write
      axi_wr(`REG_CTRL_OFS, 32'h1);
      inhibit = 1'h1;
      t_op(addrs[3], 2'h2, 1'h1, 2'h0, 16'h5A5A, 1'h0, 1'h1);
      t_op(addrs[3], 2'h2, 1'h0, 2'h3, 16'h0, 1'h0, 1'h0);
      axi_rd(`REG_CTRL_OFS, 32'h1, `RESP_OKAY);
      axi_wr(`REG_CTRL_OFS, 32'h0);
      inhibit = 1'h0;
      axi_rd(`REG_WCOUNT_OFS, 32'(wc), `RESP_OKAY);
      axi_rd(`REG_ACOUNT_OFS, 32'(ac), `RESP_OKAY);
      axi_rd(`REG_RCOUNT_OFS, 32'(rc), `RESP_OKAY);
      // Idle controller leaves the scrambled address and an open latch
      a = ~addrs[3];
      axi_rd(`REG_STATUS_OFS, {18'h00040, a}, `RESP_OKAY);
      report_and_stop;
   end
   // Watchdog: the whole sequence needs well under a thousand edges
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      report_and_stop;
   end
endmodule
bind sync_sram_byte_write_latch sync_sram_byte_write_latch_checker #(.DATA_W(DATA_W)) u_chk (
   .aclk, .aresetn, .registered_write_select_n, .bank_pick_high, .bank_pick_low_n,
   .output_enable_n, .shared_data_pins_out, .shared_data_pins_oe, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
